// file: ucep_top.sv
// Purpose: Endpoint-zero control/status, common event mask and flags, frame number,
//   endpoint selector and IN max packet size registers of a full-speed USB device
// Assumes: Protocol engine events are one-cycle pulses on CORE_CLK; bus reset
//   line is a level from the pin domain
// Notes: Other endpoint registers live elsewhere and use ENDPOINT_SELECTOR
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module ucep_top
  import ucep_pkg::*;
#(
  parameter int MAXI_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  input wire logic SOF_SEEN,
  input wire logic [10:0] SOF_FRAME,
  input wire logic BUS_RESET_PIN,
  input wire logic RESUME_SEEN,
  input wire logic SUSPEND_SEEN,
  input wire logic EP0_SETUP_END_EV,
  input wire logic EP0_RX_DONE,
  input wire logic EP0_TX_DONE,
  input wire logic EP0_STALL_DONE,
  input wire logic EP0_DATA_END_TAKEN,
  input wire logic EP0_IRQ_EN,
  output logic EP0_STALL_REQ,
  output logic EP0_DATA_END,
  output logic EP0_TX_READY,
  output logic EP0_FIFO_FLUSH,
  output logic EP0_IRQ_REQ,
  output logic [3:0] ENDPOINT_SELECTOR,
  output logic [MAXI_W-1:0] IN_MAX_PACKET_SIZE,
  output logic [3:0] COMMON_IRQ_REQ,
  output logic IRQ
);
  logic [3:0] cie_reg;
  logic [10:0] frame_reg;
  logic [3:0] index_reg;
  logic [MAXI_W-1:0] maxi_reg;
  logic stall_req_reg;
  logic early_end_reg;
  logic data_end_reg;
  logic stall_sent_reg;
  logic tx_loaded_reg;
  logic rx_present_reg;
  logic flush_reg;
  logic ep0_irq_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic bus_reset_sync;
  logic bus_reset_dly_reg;
  logic [3:0] common_flags;
  logic [3:0] common_set;
  logic [3:0] common_clr;
  logic [1:0] irq_stat;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] cs0_view;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_cie = WR_STB && hit(ADDR, OFS_CIE);
  wire wr_index = WR_STB && hit(ADDR, OFS_INDEX);
  wire wr_maxi = WR_STB && hit(ADDR, OFS_MAXI);
  wire cs0_sel = (index_reg == INDEX_RESET);
  wire wr_cs0 = WR_STB && hit(ADDR, OFS_CS0) && cs0_sel;
  wire rd_cif = RD_STB && hit(ADDR, OFS_CIF);
  wire wr_istat = WR_STB && hit(ADDR, OFS_IRQ_STAT);
  wire wr_imask = WR_STB && hit(ADDR, OFS_IRQ_MASK);

  ucep_sync #(
    .W(1)
  ) u_rst_sync (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .d(BUS_RESET_PIN),
    .q(bus_reset_sync)
  );

  wire bus_reset_rise = bus_reset_sync && !bus_reset_dly_reg;

  assign common_set = {SOF_SEEN, bus_reset_rise, RESUME_SEEN, SUSPEND_SEEN};
  assign common_clr = {4{rd_cif}};

  ucep_sticky #(
    .W(4)
  ) u_common_flags (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .set(common_set),
    .clr(common_clr),
    .q(common_flags)
  );

  // Endpoint-zero request pulses whenever a reporting event occurs and is enabled
  wire ep0_event = EP0_SETUP_END_EV || EP0_RX_DONE || (EP0_TX_DONE && tx_loaded_reg)
    || EP0_STALL_DONE;
  wire ep0_irq_next = ep0_event && EP0_IRQ_EN;

  assign irq_set = {|(common_flags & cie_reg), ep0_irq_next};
  assign irq_clr = wr_istat ? WDATA[1:0] : 2'h0;

  ucep_sticky #(
    .W(2)
  ) u_irq_stat (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_stat)
  );

  assign cs0_view = {1'b0, 1'b0, 1'b0, early_end_reg, data_end_reg, stall_sent_reg,
    tx_loaded_reg, rx_present_reg};

  always_comb begin
    rdata_next = ZERO_BYTE;
    if (hit(ADDR, OFS_CIE)) begin
      rdata_next = {4'h0, cie_reg};
    end else if (hit(ADDR, OFS_FRML)) begin
      rdata_next = frame_reg[7:0];
    end else if (hit(ADDR, OFS_FRMH)) begin
      rdata_next = {5'h00, frame_reg[10:8]};
    end else if (hit(ADDR, OFS_INDEX)) begin
      rdata_next = {4'h0, index_reg};
    end else if (hit(ADDR, OFS_MAXI)) begin
      rdata_next = 8'(maxi_reg);
    end else if (hit(ADDR, OFS_CS0)) begin
      rdata_next = cs0_sel ? cs0_view : ZERO_BYTE;
    end else if (hit(ADDR, OFS_CIF)) begin
      rdata_next = {4'h0, common_flags};
    end else if (hit(ADDR, OFS_IRQ_STAT)) begin
      rdata_next = {6'h00, irq_stat};
    end else if (hit(ADDR, OFS_IRQ_MASK)) begin
      rdata_next = {6'h00, irq_mask_reg};
    end
  end

  // Configuration registers
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cie_reg <= CIE_RESET[3:0];
      index_reg <= INDEX_RESET;
      maxi_reg <= '0;
      irq_mask_reg <= 2'h0;
      rdata_reg <= ZERO_BYTE;
      frame_reg <= 11'h000;
      bus_reset_dly_reg <= 1'b0;
    end else begin
      bus_reset_dly_reg <= bus_reset_sync;
      if (wr_cie) begin
        cie_reg <= WDATA[3:0];
      end
      // Out-of-range selectors are stored as written; software keeps to 0..5
      if (wr_index) begin
        index_reg <= WDATA[3:0];
      end
      if (wr_maxi) begin
        maxi_reg <= WDATA[MAXI_W-1:0];
      end
      if (wr_imask) begin
        irq_mask_reg <= WDATA[1:0];
      end
      if (SOF_SEEN) begin
        frame_reg <= SOF_FRAME;
      end
      if (RD_STB) begin
        rdata_reg <= rdata_next;
      end else begin
        rdata_reg <= ZERO_BYTE;
      end
    end
  end

  // Endpoint-zero control and status; hardware sets and clears beat firmware writes
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stall_req_reg <= 1'b0;
      early_end_reg <= 1'b0;
      data_end_reg <= 1'b0;
      stall_sent_reg <= 1'b0;
      tx_loaded_reg <= 1'b0;
      rx_present_reg <= 1'b0;
      flush_reg <= 1'b0;
      ep0_irq_reg <= 1'b0;
    end else begin
      ep0_irq_reg <= ep0_irq_next;
      flush_reg <= EP0_SETUP_END_EV;
      if (EP0_SETUP_END_EV) begin
        early_end_reg <= 1'b1;
      end else if (wr_cs0 && WDATA[CS0_EARLY_CLR]) begin
        early_end_reg <= 1'b0;
      end
      if (EP0_RX_DONE) begin
        rx_present_reg <= 1'b1;
      end else if (wr_cs0 && WDATA[CS0_RX_CLR]) begin
        rx_present_reg <= 1'b0;
      end
      if (EP0_STALL_DONE) begin
        stall_req_reg <= 1'b0;
      end else if (wr_cs0 && WDATA[CS0_SEND_STALL]) begin
        stall_req_reg <= 1'b1;
      end
      if (EP0_STALL_DONE) begin
        stall_sent_reg <= 1'b1;
      end else if (wr_cs0 && !WDATA[CS0_STALL_SENT]) begin
        stall_sent_reg <= 1'b0;
      end
      if (EP0_TX_DONE || EP0_SETUP_END_EV) begin
        tx_loaded_reg <= 1'b0;
      end else if (wr_cs0 && WDATA[CS0_TX_LOADED]) begin
        tx_loaded_reg <= 1'b1;
      end
      if (EP0_DATA_END_TAKEN || EP0_SETUP_END_EV) begin
        data_end_reg <= 1'b0;
      end else if (wr_cs0 && WDATA[CS0_DATA_END]) begin
        data_end_reg <= 1'b1;
      end
    end
  end

  assign RDATA = rdata_reg;
  assign EP0_STALL_REQ = stall_req_reg;
  assign EP0_DATA_END = data_end_reg;
  assign EP0_TX_READY = tx_loaded_reg;
  assign EP0_FIFO_FLUSH = flush_reg;
  assign EP0_IRQ_REQ = ep0_irq_reg;
  assign ENDPOINT_SELECTOR = index_reg;
  assign IN_MAX_PACKET_SIZE = maxi_reg;
  assign COMMON_IRQ_REQ = common_flags & cie_reg;
  assign IRQ = |(irq_stat & irq_mask_reg);
endmodule

// file: ucep_pkg.sv
// Purpose: Constants for the endpoint-zero control and common register block
// Assumes: Byte-wide registers at the printed byte offsets
// Notes: Offsets of the own status, mask and flag registers are local choices
package ucep_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CIE = 16'hDE0B;
  localparam logic [15:0] OFS_FRML = 16'hDE0C;
  localparam logic [15:0] OFS_FRMH = 16'hDE0D;
  localparam logic [15:0] OFS_INDEX = 16'hDE0E;
  localparam logic [15:0] OFS_MAXI = 16'hDE10;
  localparam logic [15:0] OFS_CS0 = 16'hDE11;
  localparam logic [15:0] OFS_CIF = 16'hDE06;
  localparam logic [15:0] OFS_IRQ_STAT = 16'hDE20;
  localparam logic [15:0] OFS_IRQ_MASK = 16'hDE21;
  localparam logic [7:0] CIE_RESET = 8'h06;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic [3:0] EP_NUM_MAX = 4'h5;
  localparam int CS0_EARLY_CLR = 7;
  localparam int CS0_RX_CLR = 6;
  localparam int CS0_SEND_STALL = 5;
  localparam int CS0_EARLY_END = 4;
  localparam int CS0_DATA_END = 3;
  localparam int CS0_STALL_SENT = 2;
  localparam int CS0_TX_LOADED = 1;
  localparam int CS0_RX_PRESENT = 0;
  localparam int EV_SOF = 3;
  localparam int EV_RST = 2;
  localparam int EV_RESUME = 1;
  localparam int EV_SUSPEND = 0;
  // Interrupt status layout: bit 0 endpoint zero, bit 1 common events
  localparam int IRQ_EP0 = 0;
  localparam int IRQ_COMMON = 1;
endpackage

// file: ucep_sticky.sv
// Purpose: Bank of sticky flags with set priority over clear
// Assumes: Clear is a one-cycle pulse on CORE_CLK; set can be a level, as the common interrupt status set is
// Notes: Used for common event flags and interrupt status
`timescale 1ns/10ps
module ucep_sticky #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  // A set in the clearing cycle wins so no event is lost
  assign q_next = set | (q_reg & ~clr);
  assign q = q_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule

// file: ucep_sync.sv
// Purpose: Two flip-flop synchroniser for pin-level inputs
// Assumes: Inputs are levels from outside the CORE_CLK domain
// Notes: Only the second stage is visible to logic
`timescale 1ns/10ps
module ucep_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  assign q = sync_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
endmodule

// file: ucep_top_monitor.sv
// Purpose: Port-level checks of the endpoint-zero register block
// Assumes: One clock domain, bound onto ucep_top
// Notes: A quiet write strobe excludes firmware writes, which the hardware clears win over anyway
`timescale 1ns/10ps
module ucep_top_monitor
  import ucep_pkg::*;
#(
  parameter int MAXI_W = 8
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic EP0_SETUP_END_EV,
  input wire logic EP0_RX_DONE,
  input wire logic EP0_TX_DONE,
  input wire logic EP0_STALL_DONE,
  input wire logic EP0_DATA_END_TAKEN,
  input wire logic EP0_IRQ_EN,
  input wire logic EP0_STALL_REQ,
  input wire logic EP0_DATA_END,
  input wire logic EP0_TX_READY,
  input wire logic EP0_FIFO_FLUSH,
  input wire logic EP0_IRQ_REQ,
  input wire logic [3:0] ENDPOINT_SELECTOR,
  input wire logic [MAXI_W-1:0] IN_MAX_PACKET_SIZE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  wire cs0_wr;
  assign cs0_wr = WR_STB && ADDR == OFS_CS0 && ENDPOINT_SELECTOR == INDEX_RESET;
  property p_flush; EP0_SETUP_END_EV |=> EP0_FIFO_FLUSH; endproperty
  a_flush: assert property (p_flush) else $error("flush missing");
  property p_flush_cause; EP0_FIFO_FLUSH |-> $past(EP0_SETUP_END_EV); endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("flush uncaused");
  property p_stall_set; cs0_wr && WDATA[5] |=> EP0_STALL_REQ; endproperty
  a_stall_set: assert property (p_stall_set) else $error("stall not requested");
  property p_stall_clr; EP0_STALL_DONE && !WR_STB |=> !EP0_STALL_REQ; endproperty
  a_stall_clr: assert property (p_stall_clr) else $error("stall not cleared");
  property p_tx_clr; EP0_TX_DONE && !WR_STB |=> !EP0_TX_READY; endproperty
  a_tx_clr: assert property (p_tx_clr) else $error("tx loaded not cleared");
  property p_de_clr; EP0_DATA_END_TAKEN && !WR_STB |=> !EP0_DATA_END; endproperty
  a_de_clr: assert property (p_de_clr) else $error("data end not cleared");
  property p_irq_rx; EP0_RX_DONE && EP0_IRQ_EN |=> EP0_IRQ_REQ; endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx request missing");
  property p_irq_off; !EP0_IRQ_EN |=> !EP0_IRQ_REQ; endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while off");
  property p_sel; WR_STB && ADDR == OFS_INDEX |=> ENDPOINT_SELECTOR == $past(WDATA[3:0]); endproperty
  a_sel: assert property (p_sel) else $error("selector not written");
  property p_maxi; WR_STB && ADDR == OFS_MAXI |=> IN_MAX_PACKET_SIZE == $past(WDATA); endproperty
  a_maxi: assert property (p_maxi) else $error("max size not written");
  cover property (EP0_STALL_DONE);
  cover property (EP0_FIFO_FLUSH);
  cover property (EP0_TX_DONE && EP0_DATA_END_TAKEN);
endmodule
bind ucep_top ucep_top_monitor #(.MAXI_W(MAXI_W)) i_mon (.CORE_CLK, .RST_B, .ADDR, .WDATA,
  .WR_STB, .EP0_SETUP_END_EV, .EP0_RX_DONE, .EP0_TX_DONE, .EP0_STALL_DONE, .EP0_DATA_END_TAKEN,
  .EP0_IRQ_EN, .EP0_STALL_REQ, .EP0_DATA_END, .EP0_TX_READY, .EP0_FIFO_FLUSH, .EP0_IRQ_REQ,
  .ENDPOINT_SELECTOR, .IN_MAX_PACKET_SIZE);

// file: ucep_host_model.sv
// Purpose: Protocol engine side answering STALL and IN packet requests
// Assumes: Requests are registered levels that fall after the answer
// Notes: DLY picks a prompt or slow answer; one pulse per request
`timescale 1ns/10ps
module ucep_host_model (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic [3:0] DLY,
  input wire logic STALL_REQ,
  input wire logic TX_READY,
  input wire logic DATA_END,
  output logic STALL_DONE,
  output logic TX_DONE,
  output logic DATA_END_TAKEN
);
  int sc;
  int tc;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sc <= 0;
      tc <= 0;
      STALL_DONE <= 1'b0;
      TX_DONE <= 1'b0;
      DATA_END_TAKEN <= 1'b0;
    end else begin
      sc <= STALL_REQ ? sc + 1 : 0;
      tc <= TX_READY ? tc + 1 : 0;
      STALL_DONE <= STALL_REQ && sc == DLY;
      TX_DONE <= TX_READY && tc == DLY;
      DATA_END_TAKEN <= DATA_END && TX_READY && tc == DLY;
    end
  end
endmodule

// file: tb_ucep_top.sv
// Purpose: Register-level test of the endpoint-zero register block
// Assumes: Reads answer one cycle after the strobe
// Notes: Event pulses share one vector: SOF, resume, suspend, setup end, rx
`timescale 1ns/10ps
module tb_ucep_top
  import ucep_pkg::*;
;
  logic CORE_CLK = 0, RST_B = 0, WR_STB = 0, RD_STB = 0, BUS_RESET_PIN = 0, EP0_IRQ_EN = 0;
  logic [15:0] ADDR = '0;
  logic [7:0] WDATA = '0, RDATA, IN_MAX_PACKET_SIZE;
  logic [10:0] SOF_FRAME = '0;
  logic [4:0] ev = '0;
  logic [3:0] dly = '0, ENDPOINT_SELECTOR, COMMON_IRQ_REQ;
  logic EP0_STALL_REQ, EP0_DATA_END, EP0_TX_READY, EP0_FIFO_FLUSH, EP0_IRQ_REQ, IRQ;
  logic STALL_DONE, TX_DONE, DE_TAKEN;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #4 CORE_CLK = ~CORE_CLK;
  ucep_top #(.MAXI_W(8)) i_dut (.CORE_CLK, .RST_B, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA,
    .SOF_SEEN(ev[4]), .SOF_FRAME, .BUS_RESET_PIN, .RESUME_SEEN(ev[3]), .SUSPEND_SEEN(ev[2]),
    .EP0_SETUP_END_EV(ev[1]), .EP0_RX_DONE(ev[0]), .EP0_TX_DONE(TX_DONE),
    .EP0_STALL_DONE(STALL_DONE), .EP0_DATA_END_TAKEN(DE_TAKEN), .EP0_IRQ_EN, .EP0_STALL_REQ,
    .EP0_DATA_END, .EP0_TX_READY, .EP0_FIFO_FLUSH, .EP0_IRQ_REQ, .ENDPOINT_SELECTOR,
    .IN_MAX_PACKET_SIZE, .COMMON_IRQ_REQ, .IRQ);
  ucep_host_model i_host (.CORE_CLK, .RST_B, .DLY(dly), .STALL_REQ(EP0_STALL_REQ),
    .TX_READY(EP0_TX_READY), .DATA_END(EP0_DATA_END), .STALL_DONE, .TX_DONE,
    .DATA_END_TAKEN(DE_TAKEN));
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
    #1;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1 chk($sformatf("reg %h", a), RDATA, e);
  endtask
  task pulse(input logic [4:0] m);
    @(posedge CORE_CLK);
    ev <= m;
    @(posedge CORE_CLK);
    ev <= '0;
    #1;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (3) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rd(OFS_CIE, CIE_RESET);
    rd(OFS_FRML, ZERO_BYTE);
    rd(OFS_FRMH, ZERO_BYTE);
    rd(OFS_INDEX, ZERO_BYTE);
    rd(OFS_MAXI, ZERO_BYTE);
    rd(OFS_CS0, ZERO_BYTE);
    rd(16'hDE0F, ZERO_BYTE);
    $display("test reset done");
    wr(OFS_CIE, 8'hFF);
    rd(OFS_CIE, 8'h0F);
    // Eight bytes: a legal full-speed size that fits any endpoint FIFO
    wr(OFS_MAXI, 8'h08);
    chk("max size", IN_MAX_PACKET_SIZE, 8'h08);
    rd(OFS_MAXI, 8'h08);
    wr(OFS_INDEX, 8'h05);
    chk("selector", {4'h0, ENDPOINT_SELECTOR}, 8'h05);
    SOF_FRAME <= 11'h5A3;
    BUS_RESET_PIN <= 1'b1;
    pulse(5'h1C);
    repeat (3) @(posedge CORE_CLK);
    #1 chk("common", {4'h0, COMMON_IRQ_REQ}, 8'h0F);
    BUS_RESET_PIN <= 1'b0;
    rd(OFS_CIF, 8'h0F);
    rd(OFS_CIF, ZERO_BYTE);
    rd(OFS_FRML, 8'hA3);
    rd(OFS_FRMH, 8'h05);
    $display("test regs done");
    pulse(5'h01);
    chk("ep0 req off", EP0_IRQ_REQ, 1'b0);
    EP0_IRQ_EN <= 1'b1;
    pulse(5'h01);
    chk("ep0 req", EP0_IRQ_REQ, 1'b1);
    rd(OFS_CS0, ZERO_BYTE);
    wr(OFS_INDEX, 8'h00);
    rd(OFS_CS0, 8'h01);
    wr(OFS_CS0, 8'h40);
    rd(OFS_CS0, ZERO_BYTE);
    wr(OFS_CS0, 8'h20);
    chk("stall req", EP0_STALL_REQ, 1'b1);
    repeat (4) @(posedge CORE_CLK);
    rd(OFS_CS0, 8'h04);
    wr(OFS_CS0, 8'h00);
    rd(OFS_CS0, ZERO_BYTE);
    $display("test stall done");
    dly <= 4'h6;
    wr(OFS_CS0, 8'h0A);
    chk("data end", {EP0_TX_READY, EP0_DATA_END}, 8'h03);
    repeat (10) @(posedge CORE_CLK);
    rd(OFS_CS0, ZERO_BYTE);
    wr(OFS_CS0, 8'h02);
    pulse(5'h02);
    chk("flush", EP0_FIFO_FLUSH, 1'b1);
    rd(OFS_CS0, 8'h10);
    wr(OFS_CS0, 8'h80);
    rd(OFS_CS0, ZERO_BYTE);
    $display("test transfer done");
    wr(OFS_IRQ_MASK, 8'h01);
    chk("irq", IRQ, 1'b1);
    wr(OFS_IRQ_STAT, 8'h03);
    chk("irq clear", IRQ, 1'b0);
    wr(OFS_IRQ_MASK, 8'h00);
    pulse(5'h01);
    chk("irq masked", IRQ, 1'b0);
    rd(OFS_IRQ_STAT, 8'h01);
    wr(OFS_IRQ_MASK, 8'h01);
    chk("irq unmasked", IRQ, 1'b1);
    $display("test irq done");
    end_of_test;
  end
endmodule
